// [core/sac_pkg.sv]
// Constants and types for the step attenuator controller
package sac_pkg;
  timeunit 1ns;
  timeprecision 1ns;

  // Word and timing
  localparam int unsigned WORD_W      = 7;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned SCK_MIN_NS  = 70;
  localparam int unsigned STB_GAP_NS  = 630;
  localparam int unsigned STB_W_NS    = 10;
  localparam int unsigned SUP_NS      = 15;
  // Half serial period rounds up so a full period is at least the minimum
  localparam int unsigned HALF_CYC    =
    (SCK_MIN_NS * CLK_MHZ + 1999) / 2000;
  localparam int unsigned GAP_CYC     =
    (STB_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STBW_CYC    =
    ((STB_W_NS * CLK_MHZ + 999) / 1000) < 2 ? 2 :
    ((STB_W_NS * CLK_MHZ + 999) / 1000);
  localparam int unsigned SUP_CYC     = (SUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned BIT_W       = 3;
  localparam logic [WORD_W-1:0] WORD_RST = 7'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;

  // Control modes
  typedef enum logic [1:0] {
    SAC_MODE_PAR_LATCHED = 2'h0,
    SAC_MODE_PAR_DIRECT  = 2'h1,
    SAC_MODE_SERIAL      = 2'h2
  } sac_mode_t;

  // User request
  typedef struct packed {
    logic [WORD_W-1:0] word;
    sac_mode_t         mode;
  } sac_req_t;

  // Pins toward the attenuator
  typedef struct packed {
    logic              mode_serial;
    logic              load_strobe;
    logic              serial_clk;
    logic              serial_word_in;
    logic [WORD_W-1:0] parallel_word_bits;
  } sac_pins_t;

endpackage

// [core/sac_tick.sv]
// Down counter giving a one-cycle pulse when a loaded delay expires
module sac_tick
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  // Status
  output logic                  done
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [CNT_W-1:0] cnt_q;
  logic             run_q;
  logic             done_q;

  wire last = run_q && (cnt_q <= 8'h01);

  // Count down, pulse on expiry
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_q  <= CNT_RST;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else if (load) begin
      cnt_q  <= count;
      run_q  <= 1'b1;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= last ? CNT_RST : cnt_q - 8'h01;
      run_q  <= run_q && !last;
      done_q <= last;
    end
  end

  assign done = done_q;

endmodule

// [core/sac_ctrl.sv]
// Host controller driving a 7-bit step attenuator's control pins
// Behaviour
// - Pulse strobe to load latched parallel words
// - Drive control pins only once power is good
// - Serial clock period never below 70 ns
// - Strobe pulses spaced at least 630 ns
// - Serial word MSB first, rising edges, strobe
// - Direct mode holds strobe high; latched pulses
module sac_ctrl
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      nrst,
  // Power status (from outside domain)
  input  wire logic      power_good,
  // User request
  input  wire logic      req_valid,
  input  sac_pkg::sac_req_t req,
  output logic           req_ready,
  // Attenuator pins
  output sac_pkg::sac_pins_t pins,
  output logic           pins_en
);
  timeunit 1ns;
  timeprecision 1ns;
  import sac_pkg::*;

  typedef enum logic [6:0] {
    ST_OFF   = 7'h01,
    ST_IDLE  = 7'h02,
    ST_SETUP = 7'h04,
    ST_CLKLO = 7'h08,
    ST_CLKHI = 7'h10,
    ST_STBHI = 7'h20,
    ST_GAP   = 7'h40
  } sac_state_t;

  sac_state_t        state_q, state_d;
  logic [2:0]        pg_q;
  logic              pg_ok_q;
  logic [WORD_W-1:0] word_q;
  sac_mode_t         mode_q;
  logic [BIT_W-1:0]  bit_q;
  sac_pins_t         pins_q;
  logic              en_q;
  logic              rdy_q;
  logic              t_load;
  logic [CNT_W-1:0]  t_count;
  logic              t_done;
  logic              hold_q;

  // Modes that keep the strobe pin up between requests
  // Used by the strobe level, the setup length and the branch choice
  function automatic logic holds_strobe(input sac_mode_t m);
    return (m == SAC_MODE_PAR_DIRECT);
  endfunction

  sac_tick u_tick (
    .clk   (clk),
    .nrst  (nrst),
    .load  (t_load),
    .count (t_count),
    .done  (t_done)
  );

  // Power good crosses in through three flops; stable when last two agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pg_q    <= 3'h0;
      pg_ok_q <= 1'b0;
    end else begin
      pg_q <= {pg_q[1:0], power_good};
      if (pg_q[2] == pg_q[1]) begin
        pg_ok_q <= pg_q[1];
      end
    end
  end

  // Sequencer decodes
  wire take      = (state_q == ST_IDLE) && req_valid;
  wire is_serial = (mode_q == SAC_MODE_SERIAL);
  wire last_bit  = (bit_q == 3'h0);

  // Leaving direct mode drops a strobe that was up; the next rise must
  // still keep the full pulse spacing, so setup stretches to the gap
  // length in that case only
  wire             from_direct = holds_strobe(mode_q) &&
                                 !holds_strobe(req.mode);
  wire [CNT_W-1:0] setup_cyc   = from_direct ? CNT_W'(GAP_CYC) :
                                               CNT_W'(SUP_CYC);

  // Parallel pin word, zero while the serial port is in use
  wire [WORD_W-1:0] par_bits = is_serial ? WORD_RST : word_q;

  // Sequencer next state and timer loads
  always_comb begin
    state_d = state_q;
    t_load  = 1'b0;
    t_count = CNT_RST;
    case (state_q)
      ST_OFF: begin
        if (pg_ok_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          state_d = ST_SETUP;
          t_load  = 1'b1;
          t_count = setup_cyc;
        end
      end
      ST_SETUP: begin
        if (t_done) begin
          t_load = 1'b1;
          if (is_serial) begin
            state_d = ST_CLKHI;
            t_count = CNT_W'(HALF_CYC);
          end else if (holds_strobe(mode_q)) begin
            state_d = ST_GAP;
            t_count = CNT_W'(GAP_CYC);
          end else begin
            state_d = ST_STBHI;
            t_count = CNT_W'(STBW_CYC);
          end
        end
      end
      ST_CLKHI: begin
        if (t_done) begin
          state_d = ST_CLKLO;
          t_load  = 1'b1;
          t_count = CNT_W'(HALF_CYC);
        end
      end
      ST_CLKLO: begin
        if (t_done) begin
          t_load = 1'b1;
          if (last_bit) begin
            state_d = ST_STBHI;
            t_count = CNT_W'(STBW_CYC);
          end else begin
            state_d = ST_CLKHI;
            t_count = CNT_W'(HALF_CYC);
          end
        end
      end
      ST_STBHI: begin
        if (t_done) begin
          state_d = ST_GAP;
          t_load  = 1'b1;
          t_count = CNT_W'(GAP_CYC);
        end
      end
      ST_GAP: begin
        if (t_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_OFF;
    endcase
    if (!pg_ok_q) begin
      state_d = ST_OFF;
    end
  end

  // State, word and bit index
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ST_OFF;
      word_q  <= WORD_RST;
      mode_q  <= SAC_MODE_PAR_LATCHED;
      bit_q   <= 3'h6;
      hold_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      // Marks the edge at which a held strobe falls
      hold_q  <= take && from_direct;
      if (take) begin
        word_q <= req.word;
        mode_q <= req.mode;
        bit_q  <= 3'h6;
      end else if (state_q == ST_CLKLO && t_done && !last_bit) begin
        bit_q <= bit_q - 3'h1;
      end
    end
  end

  // Strobe level: a load pulse, or held up while powered in direct mode
  wire strobe_hi = (state_q == ST_STBHI) ||
                   (holds_strobe(mode_q) && state_q != ST_OFF);

  // Pin drive; strobe idles low outside direct mode so power-up from reset lands in maximum attenuation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pins_q <= '0;
      en_q   <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      en_q  <= pg_ok_q;
      rdy_q <= (state_d == ST_IDLE) && !take;
      pins_q.mode_serial    <= is_serial;
      pins_q.load_strobe    <= strobe_hi;
      pins_q.serial_clk     <= (state_q == ST_CLKLO);
      pins_q.serial_word_in <= is_serial ? word_q[bit_q] : 1'b0;
      // Parallel bits carry the weighted word; old bits outlast a held strobe
      if (!hold_q) begin
        pins_q.parallel_word_bits <= par_bits;
      end
    end
  end

  assign pins      = pins_q;
  assign pins_en   = en_q;
  assign req_ready = rdy_q;

endmodule

// [tb/sac_ctrl_asserts.sv]
// Pin protocol checker for the attenuator controller
module sac_ctrl_asserts
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // User side
  input wire logic               power_good,
  input wire logic               req_valid,
  input wire sac_pkg::sac_req_t  req,
  input wire logic               req_ready,
  // Pin side
  input wire sac_pkg::sac_pins_t pins,
  input wire logic               pins_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic       sck_q;
  logic [2:0] n_q;
  logic [5:0] g_q;
  // Serial rises per word and cycles since strobe fell
  always_ff @(posedge clk) begin
    sck_q <= pins.serial_clk;
    if (!nrst || !pins_en || pins.load_strobe) n_q <= 3'h0;
    else if (pins.serial_clk && !sck_q) n_q <= n_q + 3'h1;
    if (!nrst) g_q <= 6'h3f;
    else if (pins.load_strobe) g_q <= 6'h00;
    else if (g_q != 6'h3f) g_q <= g_q + 6'h01;
  end
  sequence s_take;
    req_valid && req_ready;
  endsequence
  property p_ser;
    s_take ##0 req.mode == SAC_MODE_SERIAL |-> ##2 pins.mode_serial &&
      pins.serial_word_in == $past(req.word[6], 2);
  endproperty
  a_ser: assert property (p_ser) else $error("serial start");
  property p_par;
    s_take ##0 req.mode != SAC_MODE_SERIAL |-> ##3 !pins.mode_serial &&
      pins.parallel_word_bits == $past(req.word, 3);
  endproperty
  a_par: assert property (p_par) else $error("parallel start");
  property p_busy;
    s_take |=> !req_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready after take");
  property p_hi;
    $rose(pins.serial_clk) |=> pins.serial_clk [*3];
  endproperty
  a_hi: assert property (p_hi) else $error("serial high short");
  property p_lo;
    $fell(pins.serial_clk) |=> !pins.serial_clk [*3];
  endproperty
  a_lo: assert property (p_lo) else $error("serial low short");
  property p_mask;
    pins.serial_clk |-> !pins.load_strobe;
  endproperty
  a_mask: assert property (p_mask) else $error("clock with strobe");
  property p_cnt;
    $rose(pins.load_strobe) && pins.mode_serial |-> n_q == 3'h7;
  endproperty
  a_cnt: assert property (p_cnt) else $error("bit count");
  property p_gap;
    $rose(pins.load_strobe) |-> g_q == 6'h3f;
  endproperty
  a_gap: assert property (p_gap) else $error("strobe spacing");
  property p_wid;
    $rose(pins.load_strobe) |=> pins.load_strobe;
  endproperty
  a_wid: assert property (p_wid) else $error("strobe width");
  property p_pwr;
    !power_good [*5] |=> !pins_en;
  endproperty
  a_pwr: assert property (p_pwr) else $error("pins without power");
endmodule
bind sac_ctrl sac_ctrl_asserts u_chk (.clk(clk), .nrst(nrst),
  .power_good(power_good), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .pins(pins), .pins_en(pins_en));

// [tb/sac_dev_model.sv]
// Behavioural attenuator driven by the controller
module sac_dev_model
  import sac_pkg::*;
(
  // Control pins
  input wire sac_pkg::sac_pins_t pins,
  // State word, bit n weighs 0.25 dB times two to the n
  output logic [WORD_W-1:0]      atten
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] sh_q;
  // Maximum attenuation at power-up, taken at once
  initial atten = 7'h7f;
  // Shift in MSB first, masked while strobe high
  always @(posedge pins.serial_clk)
    if (pins.mode_serial && !pins.load_strobe)
      sh_q = {sh_q[5:0], pins.serial_word_in};
  // Strobe rise loads the shifted word
  always @(posedge pins.load_strobe)
    if (pins.mode_serial) atten = sh_q;
  // Parallel bits pass while strobe high
  always @*
    if (!pins.mode_serial && pins.load_strobe)
      atten = pins.parallel_word_bits;
endmodule

// [tb/testbench.sv]
// Self-checking bench for the attenuator controller
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sac_pkg::*;
  logic      clk, nrst, power_good, req_valid, req_ready, pins_en;
  sac_req_t  req;
  sac_pins_t pins, pins_w;
  logic [6:0] atten;
  int seed, err_count, compares, cyc, i;
  sac_ctrl u_dut (.clk(clk), .nrst(nrst), .power_good(power_good),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .pins(pins), .pins_en(pins_en));
  // Released pins fall to the pull-down level
  assign pins_w = pins_en ? pins : '0;
  sac_dev_model u_dev (.pins(pins_w), .atten(atten));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [6:0] e, logic [6:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // Wait for ready, hand over one word, wait for the end
  task automatic send(sac_mode_t m, logic [6:0] w);
    while (req_ready !== 1'b1) @(negedge clk);
    req_valid = 1;
    req = '{w, m};
    @(negedge clk);
    req_valid = 0;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    chk("atten", w, atten);
  endtask
  initial begin
    seed = 21;
    nrst = 0;
    power_good = 0;
    req_valid = 0;
    req = '0;
    repeat (4) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    chk("pins_en", 7'h00, {6'h00, pins_en});
    power_good = 1;
    repeat (20) @(negedge clk);
    chk("atten", 7'h7f, atten);
    send(SAC_MODE_SERIAL, 7'h7f);
    send(SAC_MODE_SERIAL, 7'h01);
    send(SAC_MODE_PAR_LATCHED, 7'h55);
    send(SAC_MODE_PAR_DIRECT, 7'h2a);
    send(SAC_MODE_SERIAL, 7'h40);
    send(SAC_MODE_PAR_DIRECT, 7'h0f);
    send(SAC_MODE_PAR_LATCHED, 7'h70);
    for (i = 0; i < 12; i++)
      send(sac_mode_t'(2'($unsigned($random(seed)) % 3)),
        7'($random(seed)));
    power_good = 0;
    repeat (70) @(negedge clk);
    chk("pins_en", 7'h00, {6'h00, pins_en});
    power_good = 1;
    send(SAC_MODE_PAR_LATCHED, 7'h33);
    complete_run();
  end
endmodule
